// >>> hdl/dual_timer_mode_control.sv
// mode control for two counter/timers: register, qualification, count enables
// assumes register strobes come from the core bus on clk; pins are async
// Functional notes
// - B ungated: runs whenever run bit set, except in mode 3 (inactive)
// - B gated: run and active irq B
// - B timer mode counts selected timebase
// - B counter mode counts pin falling edges
// - B mode: 13,16,8 reload, inactive
// - A ungated: runs whenever run bit set
// - A gated: run and active irq A
// - A mode: 13,16,8 reload, split 8
// - polarity bit picks irq active level
// - B overflow flag set, cleared sw/vector
`timescale 1ns/1ps
`include "dual_timer_map.svh"
module dual_timer_mode_control
    import dual_timer_pkg::*;
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrite,
    input  wire logic [7:0] regWdata,
    output byte_t           regRdata,
    input  wire logic tmr_a_run,
    input  wire logic tmr_b_run,
    input  wire logic ext_irq_a,
    input  wire logic ext_irq_b,
    input  wire logic ext_irq_a_polarity,
    input  wire logic ext_irq_b_polarity,
    input  wire logic tmrATick,
    input  wire logic tmrBTick,
    input  wire logic tmr_a_count_pin,
    input  wire logic tmr_b_count_pin,
    input  wire logic tmrBOverflow,
    input  wire logic tmrBFlagClear,
    input  wire logic tmrBVectored,
    output mode_t           tmr_a_mode_field,
    output mode_t           tmr_b_mode_field,
    output logic            tmrAIncr,
    output logic            tmrBIncr,
    output logic            tmrASplit,
    output logic            tmr_b_overflow_flag
);
    byte_t modeSel_q;
    logic  flagB_q;
    logic  pinALvl, pinAFall, pinBLvl, pinBFall;
    logic  irqALvl, irqBLvl;

    // index 0..3: count pin a, count pin b, irq a, irq b
    wire  [3:0] pinRaw = {ext_irq_b, ext_irq_a, tmr_b_count_pin, tmr_a_count_pin};
    logic [3:0] pinLvl;
    logic [3:0] pinFall;

    // all four pins pass the same synchroniser; edge pulses only used for counts
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_pin_sync
            timer_edge_sync uSync
            (
                .clk       (clk),
                .sys_rst   (sys_rst),
                .pinIn     (pinRaw[gi]),
                .levelOut  (pinLvl[gi]),
                .fallPulse (pinFall[gi])
            );
        end
    endgenerate

    assign pinALvl  = pinLvl[0];
    assign pinAFall = pinFall[0];
    assign pinBLvl  = pinLvl[1];
    assign pinBFall = pinFall[1];
    assign irqALvl  = pinLvl[2];
    assign irqBLvl  = pinLvl[3];

    wire modeWr = regWrite && (regAddr == `TMR_MODE_SEL_ADDR);
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            modeSel_q <= `TMR_MODE_SEL_RESET;
        else if (modeWr)
            modeSel_q <= regWdata;
    end
    assign regRdata = modeSel_q;

    wire tmr_b_gate_enable  = modeSel_q[`TMR_B_GATE_BIT];
    wire tmr_b_count_select = modeSel_q[`TMR_B_CNTSEL_BIT];
    wire tmr_a_gate_enable  = modeSel_q[`TMR_A_GATE_BIT];
    wire tmr_a_count_select = modeSel_q[`TMR_A_CNTSEL_BIT];
    assign tmr_b_mode_field = modeSel_q[`TMR_B_MODE_HI:`TMR_B_MODE_LO];
    assign tmr_a_mode_field = modeSel_q[`TMR_A_MODE_HI:`TMR_A_MODE_LO];

    // polarity 1 means active high; same xnor form for both inputs
    wire irqAActive = ~(irqALvl ^ ext_irq_a_polarity);
    wire irqBActive = ~(irqBLvl ^ ext_irq_b_polarity);

    wire runA = tmr_a_run && (!tmr_a_gate_enable || irqAActive);
    wire runB = tmr_b_run && (!tmr_b_gate_enable || irqBActive)
              && (tmr_b_mode_field != `TMR_MODE_SPECIAL);

    wire srcA = tmr_a_count_select ? pinAFall : tmrATick;
    wire srcB = tmr_b_count_select ? pinBFall : tmrBTick;

    assign tmrAIncr  = runA && srcA;
    assign tmrBIncr  = runB && srcB;
    assign tmrASplit = (tmr_a_mode_field == `TMR_MODE_SPECIAL);

    // set wins over either clear so an overflow is never lost
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            flagB_q <= 1'b0;
        else if (tmrBOverflow)
            flagB_q <= 1'b1;
        else if (tmrBFlagClear || tmrBVectored)
            flagB_q <= 1'b0;
    end
    assign tmr_b_overflow_flag = flagB_q;

    // properties read the synchronised levels, so pin latency never trips them
    chk_b_ungated_run: assert property (@(posedge clk) disable iff (sys_rst)
        (!tmr_b_gate_enable && tmr_b_run && tmrBTick && !tmr_b_count_select
         && tmr_b_mode_field != `TMR_MODE_SPECIAL) |-> tmrBIncr)
        else $error("timer b ungated did not count");

    chk_b_run_off: assert property (@(posedge clk) disable iff (sys_rst)
        !tmr_b_run |-> !tmrBIncr)
        else $error("timer b counted while stopped");

    chk_b_gate_block: assert property (@(posedge clk) disable iff (sys_rst)
        (tmr_b_gate_enable && !irqBActive) |-> !tmrBIncr)
        else $error("timer b counted while gate inactive");

    chk_b_gate_pass: assert property (@(posedge clk) disable iff (sys_rst)
        (tmr_b_gate_enable && tmr_b_run && (irqBLvl == ext_irq_b_polarity) && tmrBTick
         && !tmr_b_count_select && tmr_b_mode_field != `TMR_MODE_SPECIAL) |-> tmrBIncr)
        else $error("timer b gated with active irq did not count");

    chk_b_timer_src: assert property (@(posedge clk) disable iff (sys_rst)
        (!tmr_b_count_select && !tmrBTick) |-> !tmrBIncr)
        else $error("timer b counted without tick");

    chk_b_pin_edge: assert property (@(posedge clk) disable iff (sys_rst)
        tmrBIncr && tmr_b_count_select |-> $fell(pinBLvl))
        else $error("timer b counter without falling edge");

    chk_b_pin_count: assert property (@(posedge clk) disable iff (sys_rst)
        (pinBFall && tmr_b_count_select && tmr_b_run && !tmr_b_gate_enable
         && tmr_b_mode_field != `TMR_MODE_SPECIAL) |-> tmrBIncr)
        else $error("timer b missed a pin falling edge");

    chk_b_mode_inactive: assert property (@(posedge clk) disable iff (sys_rst)
        (tmr_b_mode_field == `TMR_MODE_SPECIAL) |-> !tmrBIncr)
        else $error("timer b counted while inactive");

    chk_b_mode_field: assert property (@(posedge clk) disable iff (sys_rst)
        modeWr |=> (tmr_b_mode_field == $past(regWdata[`TMR_B_MODE_HI:`TMR_B_MODE_LO])))
        else $error("timer b mode field not taken from write");

    chk_a_ungated_run: assert property (@(posedge clk) disable iff (sys_rst)
        (!tmr_a_gate_enable && tmr_a_run && tmrATick && !tmr_a_count_select)
        |-> tmrAIncr)
        else $error("timer a ungated did not count");

    chk_a_run_off: assert property (@(posedge clk) disable iff (sys_rst)
        !tmr_a_run |-> !tmrAIncr)
        else $error("timer a counted while stopped");

    chk_a_gate_block: assert property (@(posedge clk) disable iff (sys_rst)
        (tmr_a_gate_enable && !irqAActive) |-> !tmrAIncr)
        else $error("timer a counted while gate inactive");

    chk_a_gate_pass: assert property (@(posedge clk) disable iff (sys_rst)
        (tmr_a_gate_enable && tmr_a_run && (irqALvl == ext_irq_a_polarity) && tmrATick
         && !tmr_a_count_select) |-> tmrAIncr)
        else $error("timer a gated with active irq did not count");

    chk_a_split_mode: assert property (@(posedge clk) disable iff (sys_rst)
        modeWr && regWdata[`TMR_A_MODE_HI:`TMR_A_MODE_LO] == `TMR_MODE_SPECIAL |=> tmrASplit)
        else $error("timer a split mode not selected");

    chk_a_mode_field: assert property (@(posedge clk) disable iff (sys_rst)
        modeWr |=> (tmr_a_mode_field == $past(regWdata[`TMR_A_MODE_HI:`TMR_A_MODE_LO])))
        else $error("timer a mode field not taken from write");

    chk_a_pin_edge: assert property (@(posedge clk) disable iff (sys_rst)
        tmrAIncr && tmr_a_count_select |-> $fell(pinALvl))
        else $error("timer a counter without falling edge");

    chk_a_timer_src: assert property (@(posedge clk) disable iff (sys_rst)
        (!tmr_a_count_select && !tmrATick) |-> !tmrAIncr)
        else $error("timer a counted without tick");

    chk_a_pin_count: assert property (@(posedge clk) disable iff (sys_rst)
        (pinAFall && tmr_a_count_select && tmr_a_run && !tmr_a_gate_enable) |-> tmrAIncr)
        else $error("timer a missed a pin falling edge");

    // a held-low pin must never give a second increment
    chk_b_one_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        (tmrBIncr && tmr_b_count_select) |=> !(tmrBIncr && tmr_b_count_select))
        else $error("timer b counted one pin edge twice");

    chk_a_one_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        (tmrAIncr && tmr_a_count_select) |=> !(tmrAIncr && tmr_a_count_select))
        else $error("timer a counted one pin edge twice");

    chk_irq_polarity: assert property (@(posedge clk) disable iff (sys_rst)
        (tmr_a_gate_enable && (irqALvl != ext_irq_a_polarity)) |-> !tmrAIncr)
        else $error("timer a counted with irq at inactive level");

    chk_b_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
        tmrBOverflow |=> tmr_b_overflow_flag)
        else $error("timer b overflow flag not set");

    chk_b_flag_clr: assert property (@(posedge clk) disable iff (sys_rst)
        (tmrBVectored && !tmrBOverflow) |=> !tmr_b_overflow_flag)
        else $error("timer b overflow flag not cleared");

    chk_b_sw_clear: assert property (@(posedge clk) disable iff (sys_rst)
        (tmrBFlagClear && !tmrBOverflow) |=> !tmr_b_overflow_flag)
        else $error("timer b overflow flag not cleared by software");

    chk_b_flag_hold: assert property (@(posedge clk) disable iff (sys_rst)
        (!tmrBOverflow && !tmrBFlagClear && !tmrBVectored)
        |=> (tmr_b_overflow_flag == $past(tmr_b_overflow_flag)))
        else $error("timer b overflow flag changed without cause");
endmodule : dual_timer_mode_control

// >>> hdl/dual_timer_map.svh
// register offset, field positions and reset value of the timer mode register
// assumes inclusion from the timer package and design files only
`ifndef DUAL_TIMER_MAP_SVH
`define DUAL_TIMER_MAP_SVH
`define TMR_MODE_SEL_ADDR   8'h89
`define TMR_MODE_SEL_RESET  8'h00
`define TMR_B_GATE_BIT      7
`define TMR_B_CNTSEL_BIT    6
`define TMR_B_MODE_HI       5
`define TMR_B_MODE_LO       4
`define TMR_A_GATE_BIT      3
`define TMR_A_CNTSEL_BIT    2
`define TMR_A_MODE_HI       1
`define TMR_A_MODE_LO       0
`define TMR_MODE13          2'h0
`define TMR_MODE16          2'h1
`define TMR_MODE8AR         2'h2
`define TMR_MODE_SPECIAL    2'h3
`endif

// >>> hdl/dual_timer_pkg.sv
// types shared by the timer mode block
// assumes the map header defines the numbers
package dual_timer_pkg;
    typedef logic [1:0] mode_t;
    typedef logic [7:0] byte_t;
endpackage : dual_timer_pkg

// >>> hdl/timer_edge_sync.sv
// two-stage synchroniser with falling-edge pulse for one external pin
// assumes pin is asynchronous to clk
`timescale 1ns/1ps
module timer_edge_sync
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic pinIn,
    output logic      levelOut,
    output logic      fallPulse
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end
        else
        begin
            meta_q <= pinIn;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end
    assign levelOut  = sync_q;
    assign fallPulse = prev_q & ~sync_q;
endmodule : timer_edge_sync

// >>> bench/ext_pin_model.sv
// far-side model: external count pins and gating irq pins
// assumes the bench requests levels on clk; count pins idle high, irq pins idle low
`timescale 1ns/1ps
module ext_pin_model
(
    input  wire logic       clk,
    input  wire logic [1:0] fallReq,
    input  wire logic [1:0] irqLvl,
    output logic      [1:0] countPin,
    output logic      [1:0] irqPin
);
    initial countPin = 2'h3;
    initial irqPin = 2'h0;
    // pin is held low while requested, so a long request is still one edge
    always @(posedge clk) countPin <= ~fallReq;
    always @(posedge clk) irqPin <= irqLvl;
endmodule : ext_pin_model

// >>> bench/dual_timer_mode_control_tb_top.sv
// bench for the timer mode block with pin model
// assumes inputs change by nba at posedge; pulses counted at negedge
`timescale 1ns/1ps
module dual_timer_mode_control_tb_top
    import dual_timer_pkg::*;
;
    logic clk = 0, sys_rst = 1, regWrite = 0, tmr_a_run = 0, tmr_b_run = 0;
    logic aPol = 1, bPol = 1, tmrATick = 0, tmrBTick = 0;
    logic tmrBOverflow = 0, tmrBFlagClear = 0, tmrBVectored = 0;
    logic [7:0] regAddr = 0, regWdata = 0;
    logic [1:0] fallReq = 0, irqLvl = 0, cPin, iPin;
    byte_t regRdata;
    mode_t aMode, bMode;
    logic aInc, bInc, split, flag;
    int fail_count = 0, tests_run = 0, aCnt = 0, bCnt = 0;
    always #12.5 clk = ~clk;
    always @(negedge clk)
    begin
        aCnt += (aInc === 1'b1);
        bCnt += (bInc === 1'b1);
    end
    ext_pin_model u_pins (.clk(clk), .fallReq(fallReq), .irqLvl(irqLvl),
        .countPin(cPin), .irqPin(iPin));
    dual_timer_mode_control u_dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata),
        .tmr_a_run(tmr_a_run), .tmr_b_run(tmr_b_run), .ext_irq_a(iPin[0]),
        .ext_irq_b(iPin[1]), .ext_irq_a_polarity(aPol), .ext_irq_b_polarity(bPol),
        .tmrATick(tmrATick), .tmrBTick(tmrBTick), .tmr_a_count_pin(cPin[0]),
        .tmr_b_count_pin(cPin[1]), .tmrBOverflow(tmrBOverflow),
        .tmrBFlagClear(tmrBFlagClear), .tmrBVectored(tmrBVectored),
        .tmr_a_mode_field(aMode), .tmr_b_mode_field(bMode), .tmrAIncr(aInc),
        .tmrBIncr(bInc), .tmrASplit(split), .tmr_b_overflow_flag(flag));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk)
        begin
            regAddr <= a;
            regWdata <= d;
            regWrite <= 1;
        end
        @(posedge clk) regWrite <= 0;
        @(negedge clk);
    endtask : wr
    // ticks on both timers, then pulse counts compared
    task automatic ticks(input int n, input logic [7:0] ea, input logic [7:0] eb);
        aCnt = 0;
        bCnt = 0;
        repeat (n) @(posedge clk)
        begin
            tmrATick <= 1;
            tmrBTick <= 1;
        end
        @(posedge clk)
        begin
            tmrATick <= 0;
            tmrBTick <= 0;
        end
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("countA", aCnt[7:0], ea);
        chk("countB", bCnt[7:0], eb);
    endtask : ticks
    task automatic t_modes;
        for (int m = 0; m < 4; m++)
        begin
            wr(8'h89, {2'h0, m[1:0], 2'h0, m[1:0]});
            chk("modeA", {6'h00, aMode}, m[7:0]);
            chk("modeB", {6'h00, bMode}, m[7:0]);
            chk("split", {7'h00, split}, {7'h00, m == 3});
        end
        wr(8'h8A, 8'hFF);
        chk("regRdata", regRdata, 8'h33);
    endtask : t_modes
    task automatic t_gate;
        @(posedge clk)
        begin
            tmr_a_run <= 1;
            tmr_b_run <= 1;
        end
        wr(8'h88, 8'h00);
        wr(8'h89, 8'h88);
        ticks(3, 8'h00, 8'h00);
        @(posedge clk)
        begin
            aPol <= 0;
            bPol <= 0;
        end
        ticks(3, 8'h03, 8'h03);
        // gate opened by the pins themselves, after the synchroniser delay
        @(posedge clk)
        begin
            aPol <= 1;
            bPol <= 1;
            irqLvl <= 2'h3;
        end
        repeat (4) @(posedge clk);
        ticks(3, 8'h03, 8'h03);
        @(posedge clk) irqLvl <= 2'h0;
        wr(8'h89, 8'h00);
        ticks(3, 8'h03, 8'h03);
        wr(8'h89, 8'h30);
        ticks(2, 8'h02, 8'h00);
        @(posedge clk) tmr_a_run <= 0;
        ticks(2, 8'h00, 8'h00);
    endtask : t_gate
    task automatic t_pins;
        @(posedge clk) tmr_a_run <= 1;
        wr(8'h89, 8'h44);
        ticks(3, 8'h00, 8'h00);
        aCnt = 0;
        bCnt = 0;
        @(posedge clk) fallReq <= 2'h3;
        repeat (4) @(posedge clk);
        fallReq <= 2'h0;
        repeat (8) @(posedge clk);
        chk("pinA", aCnt[7:0], 8'h01);
        chk("pinB", bCnt[7:0], 8'h01);
    endtask : t_pins
    task automatic t_flag;
        @(posedge clk) tmrBOverflow <= 1;
        @(posedge clk)
        begin
            tmrBOverflow <= 0;
            tmrBFlagClear <= 1;
        end
        @(negedge clk) chk("flagSet", {7'h00, flag}, 8'h01);
        @(posedge clk)
        begin
            tmrBFlagClear <= 0;
            tmrBOverflow <= 1;
        end
        @(negedge clk) chk("flagClr", {7'h00, flag}, 8'h00);
        @(posedge clk)
        begin
            tmrBOverflow <= 0;
            tmrBVectored <= 1;
        end
        @(posedge clk) tmrBVectored <= 0;
        @(negedge clk) chk("flagVec", {7'h00, flag}, 8'h00);
        // overflow and both clears in one cycle: the set must win
        @(posedge clk)
        begin
            tmrBOverflow <= 1;
            tmrBFlagClear <= 1;
            tmrBVectored <= 1;
        end
        @(posedge clk)
        begin
            tmrBOverflow <= 0;
            tmrBFlagClear <= 0;
            tmrBVectored <= 0;
        end
        @(negedge clk) chk("flagWins", {7'h00, flag}, 8'h01);
    endtask : t_flag
    // second reset in mid-run must clear register and flag again
    task automatic t_reset;
        wr(8'h89, 8'h5A);
        chk("regMixed", regRdata, 8'h5A);
        chk("flagBefore", {7'h00, flag}, 8'h01);
        @(posedge clk) sys_rst <= 1;
        repeat (3) @(posedge clk);
        sys_rst <= 0;
        @(negedge clk);
        chk("midReg", regRdata, 8'h00);
        chk("midFlag", {7'h00, flag}, 8'h00);
        chk("midSplit", {7'h00, split}, 8'h00);
    endtask : t_reset
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict
    // the whole sequence needs about 106 cycles; the limit of 800 cycles allows over seven times that
    initial
    begin
        #20000;
        fail_count++;
        print_verdict();
    end
    initial
    begin
        repeat (3) @(posedge clk);
        sys_rst <= 0;
        @(negedge clk);
        chk("resetReg", regRdata, 8'h00);
        chk("resetFlag", {7'h00, flag}, 8'h00);
        t_modes();
        t_gate();
        t_pins();
        t_flag();
        t_reset();
        print_verdict();
    end
endmodule : dual_timer_mode_control_tb_top
